/* File: design/compat_io_alarm_logic.sv */
// discrete i/o, stop, alarm and alarm-report logic with an AXI4-Lite register slave
// assumes motion and protection logic on aclk, host pins asynchronous
`timescale 1ns/1ps
`include "compat_io_consts.svh"

// What this block does
// - Brake/clear line is normally closed; open line means stop.
// - Line is run-permit normally, alarm-clear while an alarm stands.
// - Run-permit must be on; dropping it stops motor and holds brake.
// - Stop action: immediate, decelerate, either plus current off; resets to 0.
// - Fault output is on without alarm, off with alarm.
// - Alarm stops motor, drops fault output, shows code, all together.
// - Clear needs line on 0.5 s then off; release clears alarm.
// - Some alarms clear only by power cycle.
// - Shared output is busy/torque normally, alarm pulses during alarm.
// - Select setting: 0 busy, 1 torque-limit; resets to 0.
// - Busy during operation, off once position settles in end window.
// - End window 1 to 100 steps of 0.72 degrees; resets to 1.
// - In alarm, start on 0.1 s then off requests pulse report.
// - Pulse count 2..10 encodes alarm type, 10 for others.
// - Torque-limit mode: output on when torque reaches limit.
// - Fourth select bit on spare input 7 or 8 gives numbers 0..15.
// - Number 6 electrical home, 7 mechanical home, others positioning.
// - Continuous setting turns numbers 0 and 1 into continuous operation.
// - Start launches the number currently on the select lines.
module compat_io_alarm_logic #(
  parameter int ADDR_W = 8,
  parameter int CLEAR_HOLD_CYCLES = `CLEAR_HOLD_MS * (`CLK_HZ / 1000),
  parameter int REPORT_HOLD_CYCLES = `REPORT_HOLD_MS * (`CLK_HZ / 1000),
  parameter int PULSE_CYCLES = `PULSE_MS * (`CLK_HZ / 1000)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic alarm_clear_in,
  input wire logic start_in,
  input wire logic data_sel_bit0,
  input wire logic data_sel_bit1,
  input wire logic data_sel_bit2,
  input wire logic spare_input_7,
  input wire logic spare_input_8,
  input wire logic alarm_event,
  input wire logic [3:0] alarm_code,
  input wire logic alarm_power_cycle_only,
  input wire logic motion_active,
  input wire logic motion_ready,
  input wire logic signed [15:0] position_error,
  input wire logic torque_limit_flag,
  output logic fault_ok_out,
  output logic status_out,
  output logic spare_output_2,
  output logic stop_request,
  output logic stop_decelerate,
  output logic current_off,
  output logic brake_hold,
  output logic start_pulse,
  output logic [3:0] op_number,
  output logic [1:0] op_kind,
  output logic [3:0] alarm_display
);

  logic [6:0] pins;
  logic line_on;
  logic start_on;
  logic [2:0] sel_low;
  logic in7;
  logic in8;

  pin_sync #(.W(7)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_in({spare_input_8, spare_input_7, data_sel_bit2, data_sel_bit1,
             data_sel_bit0, start_in, alarm_clear_in}),
    .pin_sync_out(pins)
  );

  assign line_on = pins[0];
  assign start_on = pins[1];
  assign sel_low = pins[4:2];
  assign in7 = pins[5];
  assign in8 = pins[6];

  // settings
  logic [1:0] stop_action;
  logic out_select;
  logic cont_en;
  logic [1:0] m3_map;
  logic [6:0] end_range;

  // alarm state
  logic alarm_active;
  logic alarm_sticky;
  logic [3:0] alarm_count;
  logic next_alarm_active;
  logic line_prev;
  logic start_prev;
  logic [31:0] clear_cnt;
  logic [31:0] report_cnt;
  logic clear_release;
  logic report_release;
  logic busy;
  logic torque_limit_out;
  logic alarm_pulse_out;
  compat_io_pkg::pulse_state_t pulse_state;
  logic [3:0] pulses_left;
  logic [31:0] pulse_cnt;

  // hold for the clear time, then the release clears
  assign clear_release = alarm_active && line_prev && !line_on &&
                         (clear_cnt >= 32'(CLEAR_HOLD_CYCLES));
  // start held for the report time, then released
  assign report_release = alarm_active && start_prev && !start_on &&
                          (report_cnt >= 32'(REPORT_HOLD_CYCLES));

  always_comb begin
    next_alarm_active = alarm_active;
    // power-cycle-only alarms ignore the clear sequence
    if (clear_release && !alarm_sticky) begin
      next_alarm_active = 1'b0;
    end
    // new alarm wins over a clear in the same cycle
    if (alarm_event) begin
      next_alarm_active = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_prev <= 1'b0;
      start_prev <= 1'b0;
    end else if (ce) begin
      line_prev <= line_on;
      start_prev <= start_on;
    end
  end

  // tick counters for the hold times, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_cnt <= 32'h0000_0000;
    end else if (ce) begin
      if (!alarm_active || !line_on) begin
        clear_cnt <= 32'h0000_0000;
      end else if (clear_cnt < 32'(CLEAR_HOLD_CYCLES)) begin
        clear_cnt <= clear_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      report_cnt <= 32'h0000_0000;
    end else if (ce) begin
      if (!alarm_active || !start_on) begin
        report_cnt <= 32'h0000_0000;
      end else if (report_cnt < 32'(REPORT_HOLD_CYCLES)) begin
        report_cnt <= report_cnt + 32'h0000_0001;
      end
    end
  end

  // alarm latch, code and fault output on the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_active <= 1'b0;
      alarm_sticky <= 1'b0;
      alarm_count <= 4'h0;
      alarm_display <= 4'h0;
      fault_ok_out <= 1'b1;
    end else if (ce) begin
      alarm_active <= next_alarm_active;
      // fault output on only without alarm
      fault_ok_out <= !next_alarm_active;
      if (alarm_event && !alarm_active) begin
        alarm_sticky <= alarm_power_cycle_only;
        alarm_display <= alarm_code;
        // codes outside 2..10 report as other
        if (alarm_code < `ALP_MIN_COUNT || alarm_code > `ALP_MAX_COUNT) begin
          alarm_count <= `ALP_MAX_COUNT;
        end else begin
          alarm_count <= alarm_code;
        end
      end else if (!next_alarm_active) begin
        alarm_sticky <= 1'b0;
        alarm_display <= 4'h0;
      end
    end
  end

  // stop control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_request <= 1'b1;
      stop_decelerate <= 1'b0;
      current_off <= 1'b0;
      brake_hold <= 1'b1;
    end else if (ce) begin
      if (next_alarm_active) begin
        // alarm stop is immediate with current removed
        stop_request <= 1'b1;
        stop_decelerate <= 1'b0;
        current_off <= 1'b1;
        brake_hold <= 1'b1;
      end else if (!line_on) begin
        // open line is the stop condition
        // run permit lost: stop and hold the brake
        // manner of stop from the setting
        stop_request <= 1'b1;
        stop_decelerate <= stop_action[0];
        current_off <= stop_action[1];
        brake_hold <= 1'b1;
      end else begin
        // line acts as run permit outside alarm
        stop_request <= 1'b0;
        stop_decelerate <= 1'b0;
        current_off <= 1'b0;
        brake_hold <= 1'b0;
      end
    end
  end

  // operation launch
  logic sel_msb;
  logic [3:0] sel_num;

  always_comb begin
    // fourth bit only when mapped to a spare input
    case (m3_map)
      compat_io_pkg::M3_SPARE7: sel_msb = in7;
      compat_io_pkg::M3_SPARE8: sel_msb = in8;
      default: sel_msb = 1'b0;
    endcase
    sel_num = {sel_msb, sel_low};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_pulse <= 1'b0;
      op_number <= 4'h0;
      op_kind <= compat_io_pkg::OP_POSITIONING;
    end else if (ce) begin
      start_pulse <= 1'b0;
      // start takes the number on the lines now
      if (start_on && !start_prev && !next_alarm_active && line_on) begin
        start_pulse <= 1'b1;
        op_number <= sel_num;
        if (sel_num == `ELEC_HOME_NUM) begin
          op_kind <= compat_io_pkg::OP_ELEC_HOME;
        end else if (sel_num == `MECH_HOME_NUM) begin
          op_kind <= compat_io_pkg::OP_MECH_HOME;
        // continuous for numbers 0 and 1
        end else if (cont_en && sel_num[3:1] == 3'b000) begin
          op_kind <= compat_io_pkg::OP_CONTINUOUS;
        end else begin
          op_kind <= compat_io_pkg::OP_POSITIONING;
        end
      end
    end
  end

  // busy and torque reporting
  logic [15:0] abs_err;
  assign abs_err = position_error[15] ? 16'(-position_error) : 16'(position_error);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      torque_limit_out <= 1'b0;
      spare_output_2 <= 1'b0;
    end else if (ce) begin
      // busy until settled inside the end window
      busy <= motion_active || (abs_err > {9'h000, end_range});
      torque_limit_out <= torque_limit_flag;
      spare_output_2 <= motion_ready && !alarm_active;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_state <= compat_io_pkg::PULSE_IDLE;
      pulses_left <= 4'h0;
      pulse_cnt <= 32'h0000_0000;
      alarm_pulse_out <= 1'b0;
    end else if (ce) begin
      case (pulse_state)
        compat_io_pkg::PULSE_IDLE: begin
          alarm_pulse_out <= 1'b0;
          if (report_release) begin
            pulse_state <= compat_io_pkg::PULSE_HIGH;
            pulses_left <= alarm_count;
            pulse_cnt <= 32'h0000_0000;
            alarm_pulse_out <= 1'b1;
          end
        end
        compat_io_pkg::PULSE_HIGH: begin
          if (pulse_cnt >= 32'(PULSE_CYCLES - 1)) begin
            pulse_cnt <= 32'h0000_0000;
            alarm_pulse_out <= 1'b0;
            pulses_left <= pulses_left - 4'h1;
            pulse_state <= compat_io_pkg::PULSE_LOW;
          end else begin
            pulse_cnt <= pulse_cnt + 32'h0000_0001;
          end
        end
        compat_io_pkg::PULSE_LOW: begin
          if (pulse_cnt >= 32'(PULSE_CYCLES - 1)) begin
            pulse_cnt <= 32'h0000_0000;
            if (pulses_left == 4'h0) begin
              pulse_state <= compat_io_pkg::PULSE_IDLE;
            end else begin
              alarm_pulse_out <= 1'b1;
              pulse_state <= compat_io_pkg::PULSE_HIGH;
            end
          end else begin
            pulse_cnt <= pulse_cnt + 32'h0000_0001;
          end
        end
        default: begin
          pulse_state <= compat_io_pkg::PULSE_IDLE;
          alarm_pulse_out <= 1'b0;
        end
      endcase
      // train ends when the alarm is cleared
      if (!next_alarm_active) begin
        pulse_state <= compat_io_pkg::PULSE_IDLE;
        alarm_pulse_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_out <= 1'b0;
    end else if (ce) begin
      if (alarm_active) begin
        status_out <= alarm_pulse_out;
      end else if (out_select) begin
        status_out <= torque_limit_out;
      end else begin
        status_out <= busy;
      end
    end
  end

  // AXI4-Lite slave
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic [7:0] wr_reg;
  logic [7:0] rd_reg;
  logic [6:0] new_range;

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_reg = 8'(wr_addr);
  assign rd_reg = 8'(s_axi_araddr);
  assign new_range = wr_data[6:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (wr_reg == `REG_CTRL || wr_reg == `REG_END_RANGE) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_action <= `STOP_ACTION_RESET;
      out_select <= `OUT_SEL_RESET;
      cont_en <= `CONT_EN_RESET;
      m3_map <= compat_io_pkg::M3_NONE;
      end_range <= `END_RANGE_RESET;
    end else if (ce && do_write && wr_strb[0]) begin
      if (wr_reg == `REG_CTRL) begin
        stop_action <= wr_data[`CTRL_STOP_HI:`CTRL_STOP_LO];
        out_select <= wr_data[`CTRL_OUT_SEL];
        cont_en <= wr_data[`CTRL_CONT_EN];
        m3_map <= wr_data[`CTRL_M3_HI:`CTRL_M3_LO];
      end else if (wr_reg == `REG_END_RANGE) begin
        if (new_range < `END_RANGE_MIN) begin
          end_range <= `END_RANGE_MIN;
        end else if (new_range > `END_RANGE_MAX || wr_data[31:7] != 25'h0) begin
          end_range <= `END_RANGE_MAX;
        end else begin
          end_range <= new_range;
        end
      end
    end
  end

  // register reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (rd_reg)
          `REG_CTRL: s_axi_rdata <= {26'h0, m3_map, cont_en, out_select, stop_action};
          `REG_END_RANGE: s_axi_rdata <= {25'h0, end_range};
          `REG_STATUS: s_axi_rdata <= {14'h0, op_kind, op_number, alarm_count,
                                       3'h0, line_on, busy, alarm_sticky,
                                       fault_ok_out, alarm_active};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: inc/compat_io_consts.svh */
// constants for the compatible-mode discrete i/o and alarm logic
// assumes a 25 MHz system clock and 32-bit AXI4-Lite register access
`ifndef COMPAT_IO_CONSTS_SVH
`define COMPAT_IO_CONSTS_SVH

`define CLK_HZ 25000000
`define CLEAR_HOLD_MS 500
`define REPORT_HOLD_MS 100
`define PULSE_MS 100

`define REG_CTRL 8'h00
`define REG_END_RANGE 8'h04
`define REG_STATUS 8'h08

`define CTRL_STOP_LO 0
`define CTRL_STOP_HI 1
`define CTRL_OUT_SEL 2
`define CTRL_CONT_EN 3
`define CTRL_M3_LO 4
`define CTRL_M3_HI 5

`define STOP_ACTION_RESET 2'h0
`define OUT_SEL_RESET 1'b0
`define CONT_EN_RESET 1'b0
`define END_RANGE_RESET 7'h01
`define END_RANGE_MIN 7'h01
`define END_RANGE_MAX 7'h64

`define ALP_MIN_COUNT 4'h2
`define ALP_MAX_COUNT 4'hA

`define ELEC_HOME_NUM 4'h6
`define MECH_HOME_NUM 4'h7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: inc/compat_io_pkg.sv */
// types for the compatible-mode discrete i/o and alarm logic
// assumes nothing beyond the constants header
package compat_io_pkg;

  typedef enum logic [1:0] {
    STOP_IMMEDIATE = 2'b00,
    STOP_DECEL = 2'b01,
    STOP_IMMEDIATE_OFF = 2'b10,
    STOP_DECEL_OFF = 2'b11
  } stop_action_t;

  typedef enum logic [1:0] {
    OP_POSITIONING = 2'b00,
    OP_CONTINUOUS = 2'b01,
    OP_ELEC_HOME = 2'b10,
    OP_MECH_HOME = 2'b11
  } op_kind_t;

  typedef enum logic [1:0] {
    M3_NONE = 2'b00,
    M3_SPARE7 = 2'b01,
    M3_SPARE8 = 2'b10
  } m3_map_t;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_HIGH = 2'b01,
    PULSE_LOW = 2'b10
  } pulse_state_t;

endpackage

/* File: design/pin_sync.sv */
// two-flop synchroniser bank for discrete pins
// assumes pins are asynchronous to aclk; ce freezes the bank
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);

  logic [W-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stage1[i] <= 1'b0;
          pin_sync_out[i] <= 1'b0;
        end else if (ce) begin
          stage1[i] <= pin_in[i];
          pin_sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

/* File: tb/compat_io_alarm_logic_checker.sv */
// assertions on the compatible-mode i/o block ports
// assumes one clock domain; bound into every instance of the block
`timescale 1ns/1ps
module compat_io_alarm_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic alarm_clear_in,
  input wire logic start_in,
  input wire logic alarm_event,
  input wire logic [3:0] alarm_code,
  input wire logic motion_active,
  input wire logic motion_ready,
  input wire logic signed [15:0] position_error,
  input wire logic torque_limit_flag,
  input wire logic fault_ok_out,
  input wire logic status_out,
  input wire logic spare_output_2,
  input wire logic stop_request,
  input wire logic brake_hold,
  input wire logic current_off,
  input wire logic start_pulse,
  input wire logic [3:0] op_number,
  input wire logic [1:0] op_kind,
  input wire logic [3:0] alarm_display
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_alarm_stop;
    alarm_event |=> !fault_ok_out && stop_request && current_off && brake_hold
      && alarm_display == $past(alarm_code);
  endproperty
  a_alarm_stop: assert property (p_alarm_stop) else $error("alarm stop missing");
  property p_fault_level;
    fault_ok_out ? alarm_display == 4'h0 : stop_request && brake_hold;
  endproperty
  a_fault_level: assert property (p_fault_level) else $error("fault level wrong");
  property p_clear_release;
    $rose(fault_ok_out) |-> !$past(alarm_clear_in, 3);
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("clear early");
  property p_line_drop;
    $fell(alarm_clear_in) && fault_ok_out |-> ##3 stop_request;
  endproperty
  a_line_drop: assert property (p_line_drop) else $error("no stop on line off");
  property p_start_launch;
    $rose(start_in) && fault_ok_out && alarm_clear_in
      ##1 (fault_ok_out && !alarm_event) [*2] |=> start_pulse;
  endproperty
  a_start_launch: assert property (p_start_launch) else $error("no launch");
  property p_kind_map;
    start_pulse |-> (op_number == 4'h6) == (op_kind == 2'h2)
      && (op_number == 4'h7) == (op_kind == 2'h3) && (op_kind != 2'h1 || op_number < 4'h2);
  endproperty
  a_kind_map: assert property (p_kind_map) else $error("operation kind wrong");
  property p_busy_on;
    $past(fault_ok_out) && $past(aresetn) && $past(aresetn, 2)
      && $past(motion_active, 2) && $past(torque_limit_flag, 2) |-> status_out;
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("status low in motion");
  property p_busy_off;
    $past(fault_ok_out) && $past(aresetn) && $past(aresetn, 2) && !$past(motion_active, 2)
      && $past(position_error, 2) == 16'sh0000 && !$past(torque_limit_flag, 2)
      |-> !status_out;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("status high at rest");
  property p_ready_out;
    $past(aresetn) && fault_ok_out == $past(fault_ok_out)
      |-> spare_output_2 == ($past(motion_ready) && fault_ok_out);
  endproperty
  a_ready_out: assert property (p_ready_out) else $error("ready output wrong");
endmodule

bind compat_io_alarm_logic compat_io_alarm_checker u_chk (.*);

/* File: tb/host_pins_model.sv */
// host pin driver: brake/clear line, start and select pins
// assumes the bench calls its tasks; pins move after rising edges
`timescale 1ns/1ps
module host_pins_model (
  input wire logic aclk,
  output logic alarm_clear_in,
  output logic start_in,
  output logic data_sel_bit0,
  output logic data_sel_bit1,
  output logic data_sel_bit2,
  output logic spare_input_7,
  output logic spare_input_8
);
  initial begin
    alarm_clear_in = 1'b0;
    start_in = 1'b0;
    {spare_input_8, spare_input_7, data_sel_bit2, data_sel_bit1, data_sel_bit0} = 5'h00;
  end
  task automatic set_line(input logic v, input int n);
    @(posedge aclk);
    alarm_clear_in <= v;
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic press_start(input logic [4:0] s, input int n);
    @(posedge aclk);
    {spare_input_8, spare_input_7, data_sel_bit2, data_sel_bit1, data_sel_bit0} <= s;
    repeat (3) @(posedge aclk);
    start_in <= 1'b1;
    repeat (n) @(posedge aclk);
    start_in <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask
endmodule

/* File: tb/test_compat_io_alarm_logic.sv */
// bench for the compatible-mode i/o block: register bus, pins, alarms
// assumes the host pin model and shortened hold and pulse counts
`timescale 1ns/1ps
module test_compat_io_alarm_logic;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, alarm_event, alarm_power_cycle_only;
  logic motion_active, motion_ready, torque_limit_flag, last_st;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb, alarm_code, op_number, alarm_display;
  logic signed [15:0] position_error;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, op_kind;
  logic fault_ok_out, status_out, spare_output_2, stop_request, stop_decelerate;
  logic current_off, brake_hold, start_pulse, alarm_clear_in, start_in;
  logic data_sel_bit0, data_sel_bit1, data_sel_bit2, spare_input_7, spare_input_8;
  logic signed [15:0] errs [5] = '{16'sd5, -16'sd4, 16'sd3, -16'sd3, 16'sd0};
  logic bexp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [3:0] codes [3] = '{4'h3, 4'hC, 4'h2};
  int pulses [3] = '{3, 10, 2};
  int mismatches = 0;
  int checks = 0;
  int launches = 0;
  int rises = 0;

  compat_io_alarm_logic #(
    .CLEAR_HOLD_CYCLES(20),
    .REPORT_HOLD_CYCLES(10),
    .PULSE_CYCLES(4)
  ) uut (.*);
  host_pins_model host (.*);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (start_pulse === 1'b1) launches++;
    if (status_out === 1'b1 && last_st === 1'b0) rises++;
    last_st <= status_out;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // one bus cycle; ready and valid are looked at mid-cycle, changed after the edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, qh, done;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      qh = s_axi_arvalid & s_axi_arready;
      done = w ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
      rr = w ? s_axi_bresp : s_axi_rresp;
      rdv = s_axi_rdata;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (qh) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  task automatic raise(input logic [3:0] c, input logic p);
    @(posedge aclk);
    alarm_event <= 1'b1;
    alarm_code <= c;
    alarm_power_cycle_only <= p;
    @(posedge aclk);
    alarm_event <= 1'b0;
    tick(1);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    final_report();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {alarm_event, alarm_power_cycle_only, motion_active, torque_limit_flag} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, alarm_code, position_error} = 68'h0;
    ce = 1'b1;
    motion_ready = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    check("reset outputs", {fault_ok_out, stop_request, brake_hold, current_off}, 4'hE);
    xfer(1'b0, 8'h00, 32'h0);
    check("ctrl reset", rdv, 32'h0);
    xfer(1'b0, 8'h0C, 32'h0);
    check("unmapped resp", rr, 2'h2);
    xfer(1'b0, 8'h04, 32'h0);
    check("window reset", rdv, 32'h1);
    xfer(1'b1, 8'h04, 32'h0);
    xfer(1'b0, 8'h04, 32'h0);
    check("window min", rdv, 32'h1);
    xfer(1'b1, 8'h04, 32'hC8);
    xfer(1'b0, 8'h04, 32'h0);
    check("window max", rdv, 32'h64);
    xfer(1'b1, 8'h04, 32'h3);
    check("write resp", rr, 2'h0);
    host.set_line(1'b1, 4);
    check("run permit", {stop_request, spare_output_2}, 2'h1);
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      position_error <= errs[i];
      motion_active <= (i == 4);
      tick(2);
      check("busy", status_out, bexp[i]);
    end
    xfer(1'b1, 8'h00, 32'h4);
    tick(1);
    check("torque idle", status_out, 1'b0);
    @(posedge aclk) torque_limit_flag <= 1'b1;
    tick(2);
    check("torque reached", status_out, 1'b1);
    @(posedge aclk) torque_limit_flag <= 1'b0;
    for (int i = 0; i < 19; i++) begin
      logic [7:0] c;
      logic [4:0] s;
      int en;
      c = i < 16 ? 8'h18 : (i < 18 ? 8'h20 : 8'h00);
      s = i < 16 ? {1'b0, i[3:0]} : (i == 16 ? 5'h10 : (i == 17 ? 5'h00 : 5'h0E));
      en = i < 16 ? i : (i == 16 ? 8 : (i == 17 ? 0 : 6));
      xfer(1'b1, 8'h00, {24'h0, c});
      host.press_start(s, 3);
      check("op number", op_number, en);
      check("op kind", op_kind, en == 6 ? 2 : en == 7 ? 3 : (en < 2 && c[3]) ? 1 : 0);
    end
    check("launch count", launches, 19);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h00, i);
      host.set_line(1'b0, 4);
      check("stop kind", {stop_request, brake_hold, stop_decelerate, current_off},
        {2'b11, i[0], i[1]});
      host.set_line(1'b1, 4);
    end
    foreach (codes[i]) begin
      raise(codes[i], 1'b0);
      check("alarm", {fault_ok_out, spare_output_2, alarm_display}, {2'b00, codes[i]});
      check("status in alarm", status_out, 1'b0);
      rises = 0;
      host.press_start(5'h00, 5);
      tick(40);
      check("short report", rises, 0);
      host.press_start(5'h00, 12);
      tick(100);
      check("pulse count", rises, pulses[i]);
      host.set_line(1'b0, 4);
      check("cleared", fault_ok_out, 1'b1);
      host.set_line(1'b1, 4);
    end
    check("no launch in alarm", launches, 19);
    host.set_line(1'b0, 4);
    raise(4'h9, 1'b0);
    host.set_line(1'b1, 5);
    host.set_line(1'b0, 4);
    check("short clear", fault_ok_out, 1'b0);
    host.set_line(1'b1, 25);
    host.set_line(1'b0, 4);
    check("late clear", fault_ok_out, 1'b1);
    host.set_line(1'b1, 4);
    raise(4'h5, 1'b1);
    host.set_line(1'b1, 25);
    host.set_line(1'b0, 4);
    check("held alarm", fault_ok_out, 1'b0);
    @(posedge aclk) aresetn <= 1'b0;
    tick(2);
    @(posedge aclk) aresetn <= 1'b1;
    tick(1);
    check("power cycle", fault_ok_out, 1'b1);
    final_report();
  end
endmodule
